// ==== include/bdport_pkg.sv ====
package bdport_pkg;

    // port geometry
    localparam int PORT_WIDTH = 8;
    localparam int ADDR_WIDTH = 4;
    localparam int PWM_CHANNELS = 3;
    localparam int PWM_FIRST_PIN = 5;

    // register offsets
    localparam logic [3:0] OFS_PIN_LEVELS = 4'h0;
    localparam logic [3:0] OFS_OUTPUT_LATCH = 4'h1;
    localparam logic [3:0] OFS_PIN_DIRECTION = 4'h2;
    localparam logic [3:0] OFS_PORT_E_DIRECTION = 4'h3;
    localparam logic [3:0] OFS_HOST_DATA = 4'h4;
    localparam logic [3:0] OFS_PORT_STATUS = 4'h5;

    // field positions in port_e_direction
    localparam int SLAVE_PORT_ENABLE_BIT = 4;
    localparam logic [7:0] PORT_E_WRITE_MASK = 8'h17;

    // field positions in port status
    localparam int STAT_SLAVE_ACTIVE_BIT = 0;
    localparam int STAT_PWM_MULTI_BIT = 1;
    localparam int STAT_HOST_WROTE_BIT = 2;

    // values after reset
    localparam logic [7:0] RST_OUTPUT_LATCH = 8'h00;
    localparam logic [7:0] RST_PIN_DIRECTION = 8'hff;
    localparam logic [7:0] RST_PORT_E_DIRECTION = 8'h07;
    localparam logic [7:0] RST_HOST_DATA = 8'h00;
    localparam logic [7:0] RST_READ_DATA = 8'h00;

    // pwm output modes: single, full forward, half bridge, full reverse
    localparam logic [1:0] PWM_MODE_SINGLE = 2'h0;

    typedef struct packed {
        logic [ADDR_WIDTH-1:0] addr;
        logic [PORT_WIDTH-1:0] wrData;
        logic wrStb;
        logic rdStb;
    } bdport_bus_type;

    typedef struct packed {
        logic [1:0] mode;
        logic [PWM_CHANNELS-1:0] chanEn;
        logic [PWM_CHANNELS-1:0] chanVal;
    } bdport_pwm_type;

    typedef struct packed {
        logic rdSel;
        logic wrSel;
    } bdport_host_type;

    typedef enum {
        BDPORT_PORT_MODE,
        BDPORT_SLAVE_IDLE,
        BDPORT_SLAVE_READ,
        BDPORT_SLAVE_WRITE
    } bdport_mode_type;

endpackage

// ==== rtl/bdport_pin_mux.sv ====
`timescale 1ns/100ps
module bdport_pin_mux
    import bdport_pkg::*;
(
    // pin control
    input wire logic dirBit,
    input wire logic latchBit,
    // slave port overlay
    input wire logic slaveRead,
    input wire logic slaveWrite,
    // pwm overlay
    input wire logic pwmEn,
    input wire logic pwmVal,
    // pad
    output logic padOut,
    output logic padOe
);

    always_comb begin
        if (pwmEn) begin
            // pwm beats port and slave data
            padOut = pwmVal;
            padOe = 1'b1;
        end else if (slaveRead) begin
            // host read drives latch, direction ignored
            padOut = latchBit;
            padOe = 1'b1;
        end else if (slaveWrite) begin
            // host write makes pin an input
            padOut = 1'b0;
            padOe = 1'b0;
        end else begin
            // direction 1 releases, 0 drives latch
            padOut = latchBit;
            padOe = ~dirBit;
        end
    end

endmodule // bdport_pin_mux

// ==== rtl/bdport_top.sv ====
`timescale 1ns/100ps
module bdport_top
    import bdport_pkg::*;
#(
    parameter int WIDTH = PORT_WIDTH
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // register port
    input wire bdport_bus_type bus,
    output logic [7:0] rdData,
    // host microprocessor strobes
    input wire bdport_host_type host,
    // pwm unit outputs
    input wire bdport_pwm_type pwm,
    // pads
    input wire logic [WIDTH-1:0] padIn,
    output logic [WIDTH-1:0] padOut,
    output logic [WIDTH-1:0] padOe,
    // status
    output logic slavePortActive
);

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [WIDTH-1:0] outputLatch_reg;
    logic [WIDTH-1:0] outputLatch_next;
    logic [WIDTH-1:0] pinDirection_reg;
    logic [WIDTH-1:0] pinDirection_next;
    logic [7:0] portEDirection_reg;
    logic [7:0] portEDirection_next;
    logic [WIDTH-1:0] hostData_reg;
    logic hostWrote_reg;
    logic hostWrote_next;
    logic [7:0] rdData_reg;
    logic [7:0] rdData_next;
    bdport_mode_type mode_reg;
    bdport_mode_type mode_next;
    logic slavePortEnable;
    logic pwmMultiOut;
    logic slaveActive;
    logic slaveRead;
    logic slaveWrite;
    logic [WIDTH-1:0] pwmEnVec;
    logic [WIDTH-1:0] pwmValVec;
    logic [7:0] statusByte;

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    function automatic logic regHit(input logic [ADDR_WIDTH-1:0] addr,
                                    input logic [3:0] ofs);
        regHit = (addr == ofs);
    endfunction

    function automatic logic [7:0] widen(input logic [WIDTH-1:0] value);
        widen = 8'(value);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // mode selection

    assign slavePortEnable = portEDirection_reg[SLAVE_PORT_ENABLE_BIT];
    assign pwmMultiOut = (pwm.mode != PWM_MODE_SINGLE);
    assign slaveActive = slavePortEnable & ~pwmMultiOut;
    assign slavePortActive = slaveActive;

    always_comb begin
        mode_next = mode_reg;
        if (!slaveActive) begin
            mode_next = BDPORT_PORT_MODE;
        end else if (host.wrSel) begin
            mode_next = BDPORT_SLAVE_WRITE;
        end else if (host.rdSel) begin
            mode_next = BDPORT_SLAVE_READ;
        end else begin
            mode_next = BDPORT_SLAVE_IDLE;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            mode_reg <= BDPORT_PORT_MODE;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // write strobe wins if the host asserts both
    assign slaveWrite = slaveActive & host.wrSel;
    assign slaveRead = slaveActive & host.rdSel & ~host.wrSel;

    ////////////////////////////////////////////////////////////////////////////
    // pwm channel placement

    always_comb begin
        pwmEnVec = '0;
        pwmValVec = '0;
        for (int i = 0; i < PWM_CHANNELS; i++) begin
            pwmEnVec[PWM_FIRST_PIN + i] = pwm.chanEn[i];
            pwmValVec[PWM_FIRST_PIN + i] = pwm.chanVal[i];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // output latch

    always_comb begin
        outputLatch_next = outputLatch_reg;
        if (bus.wrStb && (regHit(bus.addr, OFS_OUTPUT_LATCH) ||
                          regHit(bus.addr, OFS_PIN_LEVELS))) begin
            // both the latch and the port address land in the latch
            outputLatch_next = bus.wrData[WIDTH-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            outputLatch_reg <= WIDTH'(RST_OUTPUT_LATCH);
        end else begin
            outputLatch_reg <= outputLatch_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // direction registers

    always_comb begin
        pinDirection_next = pinDirection_reg;
        if (bus.wrStb && regHit(bus.addr, OFS_PIN_DIRECTION)) begin
            pinDirection_next = bus.wrData[WIDTH-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            pinDirection_reg <= WIDTH'(RST_PIN_DIRECTION);
        end else begin
            pinDirection_reg <= pinDirection_next;
        end
    end

    always_comb begin
        portEDirection_next = portEDirection_reg;
        if (bus.wrStb && regHit(bus.addr, OFS_PORT_E_DIRECTION)) begin
            // flag bits above are not writable here
            portEDirection_next = bus.wrData & PORT_E_WRITE_MASK;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            portEDirection_reg <= RST_PORT_E_DIRECTION;
        end else begin
            portEDirection_reg <= portEDirection_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // host write capture

    always_ff @(posedge mclk) begin
        if (srst) begin
            hostData_reg <= WIDTH'(RST_HOST_DATA);
        end else if (slaveWrite) begin
            hostData_reg <= padIn;
        end
    end

    always_comb begin
        hostWrote_next = hostWrote_reg;
        if (bus.rdStb && regHit(bus.addr, OFS_HOST_DATA)) begin
            hostWrote_next = 1'b0;
        end
        // a new host byte wins over the clear
        if (slaveWrite) begin
            hostWrote_next = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            hostWrote_reg <= 1'b0;
        end else begin
            hostWrote_reg <= hostWrote_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register read

    always_comb begin
        statusByte = '0;
        statusByte[STAT_SLAVE_ACTIVE_BIT] = slaveActive;
        statusByte[STAT_PWM_MULTI_BIT] = pwmMultiOut;
        statusByte[STAT_HOST_WROTE_BIT] = hostWrote_reg;
    end

    always_comb begin
        rdData_next = RST_READ_DATA;
        if (bus.rdStb) begin
            case (bus.addr)
                OFS_PIN_LEVELS: rdData_next = widen(padIn);
                OFS_OUTPUT_LATCH: rdData_next = widen(outputLatch_reg);
                OFS_PIN_DIRECTION: rdData_next = widen(pinDirection_reg);
                OFS_PORT_E_DIRECTION: rdData_next = portEDirection_reg;
                OFS_HOST_DATA: rdData_next = widen(hostData_reg);
                OFS_PORT_STATUS: rdData_next = statusByte;
                default: rdData_next = RST_READ_DATA;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rdData_reg <= RST_READ_DATA;
        end else begin
            rdData_reg <= rdData_next;
        end
    end

    assign rdData = rdData_reg;

    ////////////////////////////////////////////////////////////////////////////
    // pin drivers

    generate
        for (genvar p = 0; p < WIDTH; p++) begin : g_pin
            bdport_pin_mux u_mux (
                .dirBit(pinDirection_reg[p]),
                .latchBit(outputLatch_reg[p]),
                .slaveRead(slaveRead),
                .slaveWrite(slaveWrite),
                .pwmEn(pwmEnVec[p]),
                .pwmVal(pwmValVec[p]),
                .padOut(padOut[p]),
                .padOe(padOe[p])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_dir_input_release: assert property (
        @(posedge mclk) disable iff (srst)
        (pinDirection_reg == '1 && !slaveRead && pwm.chanEn == '0) |-> (padOe == '0))
        else $error("input pin still driven");

    a_dir_output_drive: assert property (
        @(posedge mclk) disable iff (srst)
        (!slaveActive && pwm.chanEn == '0)
            |-> (padOe == ~pinDirection_reg && (padOut & padOe) == (outputLatch_reg & padOe)))
        else $error("output pin not driven from latch");

    a_latch_write_store: assert property (
        @(posedge mclk) disable iff (srst)
        (bus.wrStb && bus.addr == OFS_OUTPUT_LATCH)
            |=> (outputLatch_reg == $past(bus.wrData[WIDTH-1:0])))
        else $error("latch write lost");

    a_latch_read_back: assert property (
        @(posedge mclk) disable iff (srst)
        (bus.rdStb && bus.addr == OFS_OUTPUT_LATCH && !bus.wrStb)
            |=> (rdData == widen($past(outputLatch_reg))))
        else $error("latch read not latch value");

    a_reset_all_input: assert property (
        @(posedge mclk)
        $fell(srst) |-> (pinDirection_reg == '1 && padOe == pwmEnVec && !slaveActive))
        else $error("pins not inputs after reset");

    a_slave_read_drive: assert property (
        @(posedge mclk) disable iff (srst)
        (slaveRead && pwm.chanEn == '0) |-> (padOe == '1 && padOut == outputLatch_reg))
        else $error("slave read not driving latch");

    a_slave_write_input: assert property (
        @(posedge mclk) disable iff (srst)
        (slaveWrite && pwm.chanEn == '0) |-> (padOe == '0) ##1 (hostData_reg == $past(padIn)))
        else $error("slave write not taken as input");

    a_pwm_blocks_slave: assert property (
        @(posedge mclk) disable iff (srst)
        (pwm.mode != PWM_MODE_SINGLE) |-> (!slavePortActive && !slaveRead && !slaveWrite))
        else $error("slave port active under multi pwm");

    a_pwm_override_pin: assert property (
        @(posedge mclk) disable iff (srst)
        pwm.chanEn[0] |-> (padOe[PWM_FIRST_PIN] && padOut[PWM_FIRST_PIN] == pwm.chanVal[0]))
        else $error("pwm channel not on its pin");

    a_port_read_pins: assert property (
        @(posedge mclk) disable iff (srst)
        (bus.rdStb && bus.addr == OFS_PIN_LEVELS) |=> (rdData == widen($past(padIn))))
        else $error("port read not pin levels");

    a_enable_from_reg: assert property (
        @(posedge mclk) disable iff (srst)
        (bus.wrStb && bus.addr == OFS_PORT_E_DIRECTION && bus.wrData[SLAVE_PORT_ENABLE_BIT]
            && pwm.mode == PWM_MODE_SINGLE)
            |=> (slavePortActive || pwm.mode != PWM_MODE_SINGLE))
        else $error("slave enable not set");

    a_mode_host_write: assert property (
        @(posedge mclk) disable iff (srst)
        slaveWrite |=> (mode_reg == BDPORT_SLAVE_WRITE))
        else $error("mode not host write");

    a_host_flag_set: assert property (
        @(posedge mclk) disable iff (srst)
        slaveWrite |=> hostWrote_reg)
        else $error("host byte flag not set");

    a_read_data_idle: assert property (
        @(posedge mclk) disable iff (srst)
        !bus.rdStb |=> (rdData == RST_READ_DATA))
        else $error("read data not cleared");

    a_port_e_mask: assert property (
        @(posedge mclk) disable iff (srst)
        (bus.wrStb && bus.addr == OFS_PORT_E_DIRECTION)
            |=> (portEDirection_reg == ($past(bus.wrData) & PORT_E_WRITE_MASK)))
        else $error("port e direction write wrong");

    a_pwm_pin_place: assert property (
        @(posedge mclk) disable iff (srst)
        (!slaveActive && pinDirection_reg == '1)
            |-> (padOe == (WIDTH'(pwm.chanEn) << PWM_FIRST_PIN)))
        else $error("pwm channels not on upper pins");

endmodule // bdport_top

// ==== tb/bdport_host_model.sv ====
`timescale 1ns/100ps
module bdport_host_model
    import bdport_pkg::*;
(
    // clock
    input wire logic mclk,
    // requests from the bench
    input wire logic hostRdReq,
    input wire logic hostWrReq,
    input wire logic [7:0] hostByte,
    input wire logic extEn,
    input wire logic [7:0] extVal,
    // pads of the port
    input wire logic [7:0] padOut,
    input wire logic [7:0] padOe,
    output bdport_host_type host,
    output logic [7:0] padIn
);
    logic [7:0] lastPad_reg;
    logic [7:0] farVal;

    // host drives its byte only while writing, else outside circuitry or nothing
    always_comb begin
        host.rdSel = hostRdReq;
        host.wrSel = hostWrReq;
        farVal = hostWrReq ? hostByte : (extEn ? extVal : ~lastPad_reg);
        padIn = (padOe & padOut) | (~padOe & farVal);
    end

    // undriven lines must not keep showing the last level
    always_ff @(posedge mclk) begin
        lastPad_reg <= padIn;
    end
endmodule // bdport_host_model

// ==== tb/bdport_top_tb.sv ====
`timescale 1ns/100ps
module bdport_top_tb
    import bdport_pkg::*;
;
    logic mclk, srst, slavePortActive, hostRdReq, hostWrReq, extEn;
    bdport_bus_type bus;
    bdport_host_type host;
    bdport_pwm_type pwm;
    logic [7:0] rdData, padIn, padOut, padOe, hostByte, extVal;
    int n_mismatch, total_checks;

    bdport_top uut (
        .mclk(mclk),
        .srst(srst),
        .bus(bus),
        .rdData(rdData),
        .host(host),
        .pwm(pwm),
        .padIn(padIn),
        .padOut(padOut),
        .padOe(padOe),
        .slavePortActive(slavePortActive)
    );

    bdport_host_model far_side (
        .mclk(mclk),
        .hostRdReq(hostRdReq),
        .hostWrReq(hostWrReq),
        .hostByte(hostByte),
        .extEn(extEn),
        .extVal(extVal),
        .padOut(padOut),
        .padOe(padOe),
        .host(host),
        .padIn(padIn)
    );

    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus.addr <= a;
        bus.wrData <= d;
        bus.wrStb <= 1'b1;
        @(posedge mclk);
        bus.wrStb <= 1'b0;
        #1;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge mclk);
        bus.addr <= a;
        bus.rdStb <= 1'b1;
        @(posedge mclk);
        bus.rdStb <= 1'b0;
        #1;
        chk(rdData, exp);
    endtask

    task automatic test_done;
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge mclk);
        n_mismatch++;
        test_done;
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        n_mismatch = 0;
        total_checks = 0;
        srst <= 1'b1;
        bus <= '0;
        pwm <= '0;
        hostRdReq <= 1'b0;
        hostWrReq <= 1'b0;
        hostByte <= 8'h00;
        extEn <= 1'b1;
        extVal <= 8'h3c;
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        #1;
        chk(padOe, 8'h00);
        rd(OFS_OUTPUT_LATCH, RST_OUTPUT_LATCH);
        rd(OFS_PIN_DIRECTION, 8'hff);
        rd(OFS_PORT_E_DIRECTION, 8'h07);
        rd(4'h9, 8'h00);
        // per-pin direction and latch drive
        wr(OFS_OUTPUT_LATCH, 8'ha5);
        wr(OFS_PIN_DIRECTION, 8'hcf);
        chk(padOe, 8'h30);
        chk(padOut & padOe, 8'h20);
        rd(OFS_PIN_LEVELS, 8'h2c);
        wr(OFS_PIN_LEVELS, 8'h3c);
        wr(OFS_PIN_DIRECTION, 8'hff);
        extVal <= 8'h00;
        rd(OFS_OUTPUT_LATCH, 8'h3c);
        rd(OFS_PIN_LEVELS, 8'h00);
        // slave port
        wr(OFS_PORT_E_DIRECTION, 8'hff);
        rd(OFS_PORT_E_DIRECTION, 8'h17);
        chk({7'h00, slavePortActive}, 8'h01);
        hostRdReq <= 1'b1;
        #1;
        chk(padOe, 8'hff);
        chk(padOut, 8'h3c);
        @(posedge mclk);
        hostRdReq <= 1'b0;
        hostWrReq <= 1'b1;
        hostByte <= 8'h66;
        wr(OFS_PIN_DIRECTION, 8'h00);
        chk(padOe, 8'h00);
        hostWrReq <= 1'b0;
        rd(OFS_PORT_STATUS, 8'h05);
        rd(OFS_HOST_DATA, 8'h66);
        rd(OFS_PORT_STATUS, 8'h01);
        // pwm overlay in single mode, then multi mode
        wr(OFS_PIN_DIRECTION, 8'hff);
        pwm <= '{mode: PWM_MODE_SINGLE, chanEn: 3'b101, chanVal: 3'b100};
        hostRdReq <= 1'b1;
        @(posedge mclk);
        #1;
        chk(padOe, 8'hff);
        chk(padOut, 8'h9c);
        pwm.mode <= 2'h1;
        @(posedge mclk);
        #1;
        chk({7'h00, slavePortActive}, 8'h00);
        chk(padOe, 8'ha0);
        chk(padOut & padOe, 8'h80);
        rd(OFS_PORT_STATUS, 8'h02);
        hostRdReq <= 1'b0;
        // reset in mid-run, pwm pins stay driven
        srst <= 1'b1;
        @(posedge mclk);
        srst <= 1'b0;
        #1;
        chk(padOe, 8'ha0);
        rd(OFS_PIN_DIRECTION, 8'hff);
        test_done;
    end
endmodule // bdport_top_tb
